// ### rtl/irq_chan_pkg.sv
// Package of offsets, bit positions and reset values for the metering interrupt block.
package irq_chan_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] IDX_EN_MAIN = 10'h22c;
  localparam logic [9:0] IDX_ST_MAIN = 10'h22d;
  localparam logic [9:0] IDX_CLR_MAIN = 10'h22e;
  localparam logic [9:0] IDX_EN_ALIAS = 10'h32c;
  localparam logic [9:0] IDX_ST_ALIAS = 10'h32d;
  localparam logic [9:0] IDX_CLR_ALIAS = 10'h32e;
  localparam logic [9:0] IDX_ZX_LIMIT = 10'h3f0;
  localparam logic [9:0] IDX_OC_THR = 10'h3f1;
  localparam logic [9:0] IDX_OV_THR = 10'h3f2;
  localparam int ADR_W = 12;
  localparam int NUM_EV = 22;
  localparam int PEAK_W = 24;
  localparam int ZX_W = 16;
  // Status and enable bit positions.
  localparam int B_HALF = 0;
  localparam int B_OVF = 3;
  localparam int B_NOLOAD = 6;
  localparam int B_ASIGN = 9;
  localparam int B_RSIGN = 10;
  localparam int B_VOLTAGE_ZERO_CROSS_TIMEOUT_I = 11;
  localparam int B_ZX_I = 12;
  localparam int B_OC = 13;
  localparam int B_VOLTAGE_ZERO_CROSS_TIMEOUT_V = 14;
  localparam int B_ZX_V = 15;
  localparam int B_OV = 16;
  localparam int B_NEW_WAVEFORM_SAMPLE = 17;
  localparam int B_CYC = 18;
  localparam int B_SAG = 19;
  localparam int B_RST = 20;
  localparam int B_CRC = 21;
  // Reset values, and the enable bits that are always forced on.
  localparam logic [NUM_EV-1:0] EN_RST = 22'h000000;
  localparam logic [NUM_EV-1:0] ST_RST = 22'h100000;
  localparam logic [NUM_EV-1:0] EN_FORCED = 22'h100000;
  localparam logic [ZX_W-1:0] ZX_LIMIT_RST = 16'hffff;
  localparam logic [PEAK_W-1:0] OC_THR_RST = 24'hffffff;
  localparam logic [PEAK_W-1:0] OV_THR_RST = 24'hffffff;
  typedef enum logic [3:0] {
    SEL_NONE = 4'h1,
    SEL_EN = 4'h2,
    SEL_ST = 4'h4,
    SEL_CLR = 4'h8
  } reg_sel_e;
endpackage : irq_chan_pkg

// ### rtl/metering_irq_channel_a_voltage.sv
// Interrupt enable and status logic for current channel one and the voltage channel.
module metering_irq_channel_a_voltage
  import irq_chan_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [2:0] i_half_full,
  input wire logic [2:0] i_energy_overflow,
  input wire logic [2:0] i_power_no_load,
  input wire logic i_active_sign,
  input wire logic i_reactive_sign,
  input wire logic i_current_zero_cross,
  input wire logic i_voltage_zero_cross,
  input wire logic i_zx_tick,
  input wire logic [PEAK_W-1:0] i_current_peak,
  input wire logic [PEAK_W-1:0] i_voltage_peak,
  input wire logic i_new_waveform_sample,
  input wire logic i_line_cycle_end,
  input wire logic i_sag_event,
  input wire logic i_soft_reset_done,
  input wire logic [31:0] i_checksum,
  output logic o_irq_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  function automatic reg_sel_e decode(input logic [ADR_W-1:0] adr);
    logic [9:0] idx;
    idx = adr[ADR_W-1:2];
    if (idx == IDX_EN_MAIN || idx == IDX_EN_ALIAS)
      return SEL_EN;
    else if (idx == IDX_ST_MAIN || idx == IDX_ST_ALIAS)
      return SEL_ST;
    else if (idx == IDX_CLR_MAIN || idx == IDX_CLR_ALIAS)
      return SEL_CLR;
    else
      return SEL_NONE;
  endfunction : decode

  logic ack_next;
  logic wr_go;
  logic rd_go;
  reg_sel_e sel;
  logic [9:0] idx;

  assign ack_next = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_go = ack_next && i_wb_we;
  assign rd_go = ack_next && !i_wb_we;
  assign sel = decode(i_wb_adr);
  assign idx = i_wb_adr[ADR_W-1:2];

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  logic [NUM_EV-1:0] enable_reg;
  logic [ZX_W-1:0] zx_limit_reg;
  logic [PEAK_W-1:0] oc_thr_reg;
  logic [PEAK_W-1:0] ov_thr_reg;
  logic [NUM_EV-1:0] status_reg;
  logic [NUM_EV-1:0] eff_en;

  // Byte lanes beyond the stored width are dropped.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      enable_reg <= EN_RST;
      zx_limit_reg <= ZX_LIMIT_RST;
      oc_thr_reg <= OC_THR_RST;
      ov_thr_reg <= OV_THR_RST;
    end
    else if (wr_go)
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (i_wb_sel[b])
        begin
          if (sel == SEL_EN)
          begin
            for (int k = 0; k < 8; k++)
            begin
              if (b * 8 + k < NUM_EV)
                enable_reg[b*8+k] <= i_wb_dat[b*8+k];
            end
          end
          if (idx == IDX_OC_THR)
            oc_thr_reg[b*8+:8] <= i_wb_dat[b*8+:8];
          if (idx == IDX_OV_THR)
            ov_thr_reg[b*8+:8] <= i_wb_dat[b*8+:8];
          if (idx == IDX_ZX_LIMIT && b < 2)
            zx_limit_reg[b*8+:8] <= i_wb_dat[b*8+:8];
        end
      end
    end
  end

  assign eff_en = enable_reg | EN_FORCED;

  ////////////////////////////////////////////////////////////////////////////
  // Event detection.

  logic [2:0] no_load_prev_reg;
  logic asign_prev_reg;
  logic rsign_prev_reg;
  logic oc_prev_reg;
  logic ov_prev_reg;
  logic [31:0] chk_prev_reg;
  logic chk_valid_reg;
  logic oc_now;
  logic ov_now;

  assign oc_now = i_current_peak > oc_thr_reg;
  assign ov_now = i_voltage_peak > ov_thr_reg;

  // The first cycle after reset only primes the sign and checksum history, so a
  // sign input that is already high when reset lifts does not count as a change.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      no_load_prev_reg <= 3'h0;
      asign_prev_reg <= 1'b0;
      rsign_prev_reg <= 1'b0;
      oc_prev_reg <= 1'b0;
      ov_prev_reg <= 1'b0;
      chk_prev_reg <= 32'h0;
      chk_valid_reg <= 1'b0;
    end
    else
    begin
      no_load_prev_reg <= i_power_no_load;
      asign_prev_reg <= i_active_sign;
      rsign_prev_reg <= i_reactive_sign;
      oc_prev_reg <= oc_now;
      ov_prev_reg <= ov_now;
      chk_prev_reg <= i_checksum;
      chk_valid_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-crossing timeouts: index 0 is current, index 1 is voltage.

  logic [1:0] zx_cross;
  logic [ZX_W-1:0] zx_cnt_reg [2];
  logic zx_armed_reg [2];
  logic zx_fire_reg [2];

  assign zx_cross = {i_voltage_zero_cross, i_current_zero_cross};

  // A timeout fires once and rearms only at the next crossing.
  for (genvar g = 0; g < 2; g++)
  begin : g_voltage_zero_cross_timeout
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
      if (!i_nrst)
      begin
        zx_cnt_reg[g] <= '0;
        zx_armed_reg[g] <= 1'b1;
        zx_fire_reg[g] <= 1'b0;
      end
      else
      begin
        zx_fire_reg[g] <= 1'b0;
        if (zx_cross[g])
        begin
          zx_cnt_reg[g] <= '0;
          zx_armed_reg[g] <= 1'b1;
        end
        else if (i_zx_tick && zx_armed_reg[g])
        begin
          if (zx_cnt_reg[g] + 16'h1 >= zx_limit_reg)
          begin
            zx_fire_reg[g] <= 1'b1;
            zx_armed_reg[g] <= 1'b0;
          end
          else
            zx_cnt_reg[g] <= zx_cnt_reg[g] + 16'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register.

  logic [NUM_EV-1:0] set_vec;
  logic [NUM_EV-1:0] clr_vec;
  logic [NUM_EV-1:0] status_next;

  always_comb
  begin
    set_vec = '0;
    set_vec[B_HALF+:3] = i_half_full;
    set_vec[B_OVF+:3] = i_energy_overflow;
    set_vec[B_NOLOAD+:3] = i_power_no_load & ~no_load_prev_reg;
    set_vec[B_ASIGN] = chk_valid_reg && (i_active_sign ^ asign_prev_reg);
    set_vec[B_RSIGN] = chk_valid_reg && (i_reactive_sign ^ rsign_prev_reg);
    set_vec[B_VOLTAGE_ZERO_CROSS_TIMEOUT_I] = zx_fire_reg[0];
    set_vec[B_ZX_I] = i_current_zero_cross;
    set_vec[B_OC] = oc_now && !oc_prev_reg;
    set_vec[B_VOLTAGE_ZERO_CROSS_TIMEOUT_V] = zx_fire_reg[1];
    set_vec[B_ZX_V] = i_voltage_zero_cross;
    set_vec[B_OV] = ov_now && !ov_prev_reg;
    set_vec[B_NEW_WAVEFORM_SAMPLE] = i_new_waveform_sample;
    set_vec[B_CYC] = i_line_cycle_end;
    set_vec[B_SAG] = i_sag_event;
    set_vec[B_RST] = i_soft_reset_done;
    set_vec[B_CRC] = chk_valid_reg && (i_checksum != chk_prev_reg);
  end

  // A clearing read empties the status; a new event in that cycle survives.
  assign clr_vec = (rd_go && sel == SEL_CLR) ? '1 : '0;
  assign status_next = (status_reg & ~clr_vec) | set_vec;

  // Bit 20 comes out of hardware reset set.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      status_reg <= ST_RST;
    else
      status_reg <= status_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer and interrupt output.

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end
    else
    begin
      o_wb_ack <= ack_next;
      if (rd_go)
      begin
        unique case (sel)
          SEL_EN: o_wb_dat <= {10'h0, eff_en};
          SEL_ST: o_wb_dat <= {10'h0, status_reg};
          SEL_CLR: o_wb_dat <= {10'h0, status_reg};
          SEL_NONE:
          begin
            if (idx == IDX_ZX_LIMIT)
              o_wb_dat <= {16'h0, zx_limit_reg};
            else if (idx == IDX_OC_THR)
              o_wb_dat <= {8'h0, oc_thr_reg};
            else if (idx == IDX_OV_THR)
              o_wb_dat <= {8'h0, ov_thr_reg};
            else
              o_wb_dat <= 32'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_irq_n <= 1'b1;
    else
      o_irq_n <= !(|(status_reg & eff_en));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence

  sequence s_clr_read;
    s_req ##0 (!i_wb_we && decode(i_wb_adr) == SEL_CLR);
  endsequence

  sequence s_plain_read;
    s_req ##0 (!i_wb_we && decode(i_wb_adr) == SEL_ST) ##0 (set_vec == '0);
  endsequence

  sequence s_en_write;
    s_req ##0 (i_wb_we && decode(i_wb_adr) == SEL_EN && i_wb_sel == 4'hf);
  endsequence

  AST_ACK_ONE_CYCLE: assert property (s_req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack not a single cycle after request");
  AST_HALF_FULL: assert property (i_half_full[1] |=> status_reg[1])
    else $error("half-full event did not set its status bit");
  AST_OVERFLOW: assert property (i_energy_overflow[2] |=> status_reg[5])
    else $error("overflow event did not set its status bit");
  AST_NO_LOAD: assert property ($rose(i_power_no_load[0]) |=> status_reg[6])
    else $error("no-load entry did not set its status bit");
  AST_SIGN: assert property (chk_valid_reg && $changed(i_active_sign) |=> status_reg[9])
    else $error("sign change did not set its status bit");
  AST_VOLTAGE_ZERO_CROSS_TIMEOUT_CUR: assert property (zx_fire_reg[0] |=> status_reg[11])
    else $error("current zero-cross timeout not flagged");
  AST_ZX_CUR: assert property (i_current_zero_cross |=> status_reg[12])
    else $error("current zero crossing not flagged");
  AST_OC: assert property (oc_now && !oc_prev_reg |=> status_reg[13])
    else $error("overcurrent not flagged");
  AST_ZX_VOLT: assert property (i_voltage_zero_cross |=> status_reg[15])
    else $error("voltage zero crossing not flagged");
  AST_SAG: assert property (i_sag_event |=> status_reg[19])
    else $error("sag event not flagged");
  AST_RST_ENABLED: assert property (status_reg[20] |=> !o_irq_n)
    else $error("reset completion did not raise interrupt");
  AST_EN_WRITE: assert property (s_en_write |=> enable_reg == $past(i_wb_dat[21:0]))
    else $error("enable write not stored");
  AST_IRQ: assert property ((status_reg & eff_en) == '0 |=> o_irq_n)
    else $error("interrupt asserted with no enabled status bit");
  AST_CLR_READ: assert property (s_clr_read |=> status_reg == $past(set_vec))
    else $error("clearing read did not clear status");
  AST_PLAIN_READ: assert property (s_plain_read |=> $stable(status_reg))
    else $error("plain status read changed status");

endmodule : metering_irq_channel_a_voltage

// ### dv/irq_host_model.sv
// Host model: Wishbone classic master that services the interrupt registers.
module irq_host_model
  import irq_chan_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_ack,
  input wire logic [31:0] i_dat,
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [ADR_W-1:0] o_adr,
  output logic [3:0] o_sel,
  output logic [31:0] o_dat,
  output logic o_hang
);
  timeunit 1ns;
  timeprecision 1ns;

  initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat, o_hang} = '0;

  //////////////////////////////////////////////////////////////////////////////
  // One access; the request holds until ack is sampled high or 20 cycles pass, then is released.
  task automatic xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    @(posedge i_mclk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= we;
    o_adr <= adr;
    o_sel <= 4'hf;
    o_dat <= wd;
    for (n = 0; n < 20 && i_ack !== 1'b1; n++)
    begin
      @(posedge i_mclk);
    end
    rd = i_dat;
    if (i_ack !== 1'b1)
      o_hang <= 1'b1;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we <= 1'b0;
  endtask : xfer

  // Interrupts are acknowledged by reading the clearing view.
  task automatic clear_irq(output logic [31:0] rd);
    xfer(1'b0, {IDX_CLR_MAIN, 2'b00}, 32'h0, rd);
  endtask : clear_irq
endmodule : irq_host_model

// ### dv/metering_irq_channel_a_voltage_test.sv
// Self-checking bench for the metering interrupt block.
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
      bad_count++; \
    end \
  end

module metering_irq_channel_a_voltage_test
  import irq_chan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [21:0] pulse = '0;
  logic tick = 1'b0;
  logic asign = 1'b0;
  logic rsign = 1'b0;
  logic [23:0] cpeak = 24'h000100;
  logic [23:0] vpeak = 24'h000100;
  logic [31:0] csum = 32'h0;
  logic cyc, stb, we, ack, hang, irq_n;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int bad_count = 0;
  int samples_checked = 0;

  always #20 clk = ~clk;

  irq_host_model host (.i_mclk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
    .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat), .o_hang(hang));

  metering_irq_channel_a_voltage uut (.i_mclk(clk), .i_nrst(rst_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_half_full(pulse[2:0]),
    .i_energy_overflow(pulse[5:3]), .i_power_no_load(pulse[8:6]), .i_active_sign(asign),
    .i_reactive_sign(rsign), .i_current_zero_cross(pulse[12]),
    .i_voltage_zero_cross(pulse[15]), .i_zx_tick(tick), .i_current_peak(cpeak),
    .i_voltage_peak(vpeak), .i_new_waveform_sample(pulse[17]),
    .i_line_cycle_end(pulse[18]), .i_sag_event(pulse[19]),
    .i_soft_reset_done(pulse[20]), .i_checksum(csum), .o_irq_n(irq_n));

  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [9:0] idx, input logic [31:0] v);
    logic [31:0] x;
    host.xfer(1'b1, {idx, 2'b00}, v, x);
  endtask : wr

  task automatic rd(input logic [9:0] idx, output logic [31:0] v);
    host.xfer(1'b0, {idx, 2'b00}, 32'h0, v);
  endtask : rd

  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Raises one event source; the timeout gets three ticks to run out.
  task automatic fire(input int b);
    @(posedge clk);
    case (b)
      B_ASIGN: asign <= ~asign;
      B_RSIGN: rsign <= ~rsign;
      B_OC: cpeak <= 24'h000101;
      B_OV: vpeak <= 24'h000101;
      B_CRC: csum <= csum + 32'h1;
      B_VOLTAGE_ZERO_CROSS_TIMEOUT_I: tick <= 1'b1;
      default: pulse[b] <= 1'b1;
    endcase
    repeat (b == B_VOLTAGE_ZERO_CROSS_TIMEOUT_I ? 3 : 1) @(posedge clk);
    pulse <= '0;
    tick <= 1'b0;
    cpeak <= 24'h000100;
    vpeak <= 24'h000100;
  endtask : fire

  //////////////////////////////////////////////////////////////////////////////
  // A mid-run reset comes with the sign input raised, which must not count as a change.
  task automatic check_reset(input logic mid);
    logic [31:0] d;
    if (mid)
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      asign <= 1'b1;
    end
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("irq after reset", 1'b0, irq_n)
    rd(IDX_EN_MAIN, d);
    `CHK("enable reset", 32'h00100000, d)
    rd(IDX_ST_ALIAS, d);
    `CHK("status reset", 32'h00100000, d)
    host.clear_irq(d);
    `CHK("clearing reset", 32'h00100000, d)
    rd(IDX_ST_MAIN, d);
    `CHK("status cleared", 32'h0, d)
    `CHK("irq released", 1'b1, irq_n)
    rd(IDX_ZX_LIMIT, d);
    `CHK("zx limit reset", 32'h0000ffff, d)
    rd(IDX_OV_THR, d);
    `CHK("ov threshold reset", 32'h00ffffff, d)
  endtask : check_reset

  task automatic check_regs();
    logic [31:0] d;
    wr(IDX_EN_ALIAS, 32'hffffffff);
    rd(IDX_EN_MAIN, d);
    `CHK("enable via alias", 32'h003fffff, d)
    wr(IDX_EN_MAIN, 32'h000a5a5a);
    rd(IDX_EN_ALIAS, d);
    `CHK("enable via main", 32'h001a5a5a, d)
    wr(10'h000, 32'hffffffff);
    rd(10'h000, d);
    `CHK("unmapped", 32'h0, d)
    wr(IDX_ST_MAIN, 32'hffffffff);
    rd(IDX_ST_MAIN, d);
    `CHK("status not writable", 32'h0, d)
    wr(IDX_ZX_LIMIT, 32'h2);
    wr(IDX_OC_THR, 32'h100);
    wr(IDX_OV_THR, 32'h100);
    rd(IDX_ZX_LIMIT, d);
    `CHK("zx limit", 32'h00000002, d)
    rd(IDX_OC_THR, d);
    `CHK("oc threshold", 32'h00000100, d)
    rd(IDX_OV_THR, d);
    `CHK("ov threshold", 32'h00000100, d)
  endtask : check_regs

  task automatic check_events(input logic en);
    logic [31:0] d, m;
    wr(IDX_EN_MAIN, en ? 32'h003fffff : 32'h0);
    for (int b = 0; b < NUM_EV; b++)
    begin
      if (b == B_VOLTAGE_ZERO_CROSS_TIMEOUT_V)
        continue;
      m = 32'h1 << b;
      if (b == B_VOLTAGE_ZERO_CROSS_TIMEOUT_I)
        m = m | (32'h1 << B_VOLTAGE_ZERO_CROSS_TIMEOUT_V);
      fire(b);
      repeat (3) @(posedge clk);
      `CHK("irq on event", !(en || b == B_RST), irq_n)
      rd((b % 2 == 1) ? IDX_ST_ALIAS : IDX_ST_MAIN, d);
      `CHK("status", m, d)
      if (b % 2 == 1)
        host.clear_irq(d);
      else
        rd(IDX_CLR_ALIAS, d);
      `CHK("clearing view", m, d)
      rd(IDX_ST_MAIN, d);
      `CHK("status after clear", 32'h0, d)
      `CHK("irq after clear", 1'b1, irq_n)
    end
  endtask : check_events

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    check_reset(1'b0);
    check_regs();
    check_events(1'b0);
    check_events(1'b1);
    check_reset(1'b1);
    print_verdict();
  end

  always @(posedge hang)
  begin
    bad_count++;
    print_verdict();
  end
endmodule : metering_irq_channel_a_voltage_test
